// ### logic/sram_ctrl_pkg.sv
// Constants, types and helpers shared by the pipelined SRAM sequencer
// Functional notes
// - Operation state advances only on edges with clock_enable_n low; otherwise everything but the sleep counter and asleep holds.
// - Load cycle with all chip selects active and write_sel_n high begins burst read.
// - addr_advance_load high during a read burst continues at the next burst address.
// - Load cycle with all selects active and write_sel_n low begins burst write.
// - Advance during write burst writes next address; all lanes high aborts beat, address advances.
// - Read with output_enable_n high still loads or advances but drives no data.
// - Load with any select inactive deselects; continue-deselect only follows an executed deselect.
// - Each low byte_write_n lane writes its byte; all lanes high writes nothing.
// - write_sel_n high at a load cycle reads and ignores every byte lane.
// - Data pins gated asynchronously: sleep forces off; reads drive only with output enable.
// - Host supplies write data two cycles after the edge registering the write.
// - Array read between first and second edges; data driven from the third edge.
// - Four-beat counter seeded by low address bits; linear or interleaved, wraps.
// - Sleep entered two cycles after sleep_request rises, left two cycles after fall.
package sram_ctrl_pkg;

  localparam int BYTE_W          = 9;
  localparam int BYTES_X36       = 4;
  localparam int BYTES_X18       = 2;
  localparam int ADDR_W_X36      = 18;
  localparam int ADDR_W_X18      = 19;
  localparam int MAX_ADDR_W      = 19;
  localparam int MAX_BYTES       = 4;
  localparam int BURST_BITS      = 2;
  localparam int WRITE_DATA_LAT  = 2;
  localparam int READ_DATA_LAT   = 2;
  localparam int SLEEP_ENTER_CYC = 2;
  localparam int SLEEP_EXIT_CYC  = 2;
  localparam int BUF_ENTRIES     = 2;

  localparam logic [1:0] SLEEP_ENTER_LAST = 2'(SLEEP_ENTER_CYC - 1);
  localparam logic [1:0] SLEEP_EXIT_LAST  = 2'(SLEEP_EXIT_CYC - 1);
  localparam logic [1:0] BEAT_FIRST       = 2'h0;
  localparam logic [1:0] BEAT_STEP        = 2'h1;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_READ,
    OP_WRITE
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DESEL,
    ST_READ,
    ST_WRITE
  } seq_state_e;

  typedef struct packed {
    op_e                   op;
    logic [MAX_ADDR_W-1:0] addr;
    logic [MAX_BYTES-1:0]  be;
  } cmd_s;

  localparam cmd_s CMD_IDLE = '{op: OP_NONE, addr: '0, be: '0};

  // Low address bits of a burst beat
  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] beat,
                                           input logic       interleaved);
    burst_low = interleaved ? (start ^ beat) : 2'(start + beat);
  endfunction

endpackage

// ### logic/two_entry_buffer.sv
// Two-entry valid/ready buffer between the array read port and the output register
`timescale 1ns/1ns
module two_entry_buffer
  import sram_ctrl_pkg::*;
#(
  parameter int WIDTH = 36
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] slot [BUF_ENTRIES];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count != 2'(BUF_ENTRIES));
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count  <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      slot[wr_ptr] <= in_data;
  end

endmodule

// ### logic/sram_sequencer.sv
// Pipelined no-turnaround synchronous SRAM: command decode, burst sequencing and array
`timescale 1ns/1ns
module sram_sequencer
  import sram_ctrl_pkg::*;
#(
  parameter int BYTES  = BYTES_X36,
  parameter int ADDR_W = ADDR_W_X36
)
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic                    chip_sel_a_n,
  input  wire logic                    chip_sel_b,
  input  wire logic                    chip_sel_c_n,
  input  wire logic                    addr_advance_load,
  input  wire logic                    write_sel_n,
  input  wire logic [BYTES-1:0]        byte_write_n,
  input  wire logic                    clock_enable_n,
  input  wire logic                    output_enable_n,
  input  wire logic                    sleep_request,
  input  wire logic                    burst_order_sel,
  input  wire logic [BYTES*BYTE_W-1:0] dq_in,
  output logic [BYTES*BYTE_W-1:0]      dq_out,
  output logic                         dq_oe,
  output logic                         asleep
);

  localparam int DW = BYTES * BYTE_W;

  // Storage array, one word per address
  logic [DW-1:0]     mem [2**ADDR_W];

  seq_state_e        state;
  seq_state_e        next_state;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [1:0]        beat;
  logic [1:0]        next_beat;
  cmd_s              s1;
  cmd_s              s2;
  cmd_s              next_cmd;
  logic [1:0]        sleep_cnt;
  logic              drive;

  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [DW-1:0]     buf_out_data;

  // Merge the late write data into a word by byte lane
  function automatic logic [DW-1:0] merge_lanes(input logic [DW-1:0]    old_word,
                                                input logic [DW-1:0]    new_word,
                                                input logic [BYTES-1:0] lanes);
    logic [DW-1:0] res;
    res = old_word;
    for (int i = 0; i < BYTES; i++)
    begin
      if (lanes[i])
        res[i*BYTE_W +: BYTE_W] = new_word[i*BYTE_W +: BYTE_W];
    end
    merge_lanes = res;
  endfunction

  // Decode
  wire               all_selected = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
  wire               load_cycle   = ~addr_advance_load;
  wire [BYTES-1:0]   lanes_on     = ~byte_write_n;
  // A stalled buffer also freezes the pipe, so a word is never dropped
  wire               step         = ~clock_enable_n & ~asleep & buf_in_ready;
  wire [1:0]         beat_inc     = 2'(beat + BEAT_STEP);
  wire [ADDR_W-1:0]  burst_addr   = {base[ADDR_W-1:BURST_BITS],
                                     burst_low(base[1:0], beat_inc, burst_order_sel)};
  wire [MAX_ADDR_W-1:0] load_addr_w  = MAX_ADDR_W'(addr);
  wire [MAX_ADDR_W-1:0] burst_addr_w = MAX_ADDR_W'(burst_addr);
  wire [MAX_BYTES-1:0]  lanes_w      = MAX_BYTES'(lanes_on);

  // Array access
  wire [ADDR_W-1:0]  rd_addr      = s1.addr[ADDR_W-1:0];
  wire [ADDR_W-1:0]  wr_addr      = s2.addr[ADDR_W-1:0];
  wire [BYTES-1:0]   wr_lanes     = s2.be[BYTES-1:0];
  wire               wr_now       = step & (s2.op == OP_WRITE);
  wire               rd_now       = (s1.op == OP_READ);
  // A write landing on the same edge must be seen by the read of that edge
  wire               fwd_hit      = (s2.op == OP_WRITE) && (wr_addr == rd_addr);
  wire [DW-1:0]      rd_word      = fwd_hit ? merge_lanes(mem[rd_addr], dq_in, wr_lanes)
                                            : mem[rd_addr];
  wire               push_read    = step & rd_now;

  always_comb
  begin
    next_state = state;
    next_base  = base;
    next_beat  = beat;
    next_cmd   = CMD_IDLE;
    if (load_cycle)
    begin
      if (all_selected)
      begin
        next_base = addr;
        next_beat = BEAT_FIRST;
        if (write_sel_n)
        begin
          next_state    = ST_READ;
          next_cmd.op   = OP_READ;
          next_cmd.addr = load_addr_w;
          next_cmd.be   = '0;
        end
        else
        begin
          next_state    = ST_WRITE;
          next_cmd.op   = OP_WRITE;
          next_cmd.addr = load_addr_w;
          next_cmd.be   = lanes_w;
        end
      end
      else
      begin
        next_state = ST_DESEL;
      end
    end
    else
    begin
      case (state)
        ST_READ:
        begin
          next_beat     = beat_inc;
          next_cmd.op   = OP_READ;
          next_cmd.addr = burst_addr_w;
        end
        ST_WRITE:
        begin
          next_beat     = beat_inc;
          next_cmd.op   = OP_WRITE;
          next_cmd.addr = burst_addr_w;
          next_cmd.be   = lanes_w;
        end
        ST_DESEL:
        begin
          next_state = ST_DESEL;
        end
        ST_IDLE:
        begin
          // No deselect has executed yet, so an advance has nothing to continue
          next_state = ST_IDLE;
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer state, held whenever the edge is ignored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      base  <= '0;
      beat  <= BEAT_FIRST;
      s1    <= CMD_IDLE;
      s2    <= CMD_IDLE;
    end
    else if (step)
    begin
      state <= next_state;
      base  <= next_base;
      beat  <= next_beat;
      s1    <= next_cmd;
      s2    <= s1;
    end
  end

  // Late write: data sampled two edges after the command
  always_ff @(posedge clk)
  begin
    if (wr_now)
    begin
      for (int i = 0; i < BYTES; i++)
      begin
        if (wr_lanes[i])
          mem[wr_addr][i*BYTE_W +: BYTE_W] <= dq_in[i*BYTE_W +: BYTE_W];
      end
    end
  end

  two_entry_buffer #(
    .WIDTH (DW)
  ) read_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_read),
    .in_ready  (buf_in_ready),
    .in_data   (rd_word),
    .out_valid (buf_out_valid),
    .out_ready (step),
    .out_data  (buf_out_data)
  );

  // Output register: the word buffered on the second edge is presented from the third
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dq_out <= '0;
      drive  <= 1'b0;
    end
    else if (step)
    begin
      drive <= buf_out_valid;
      if (buf_out_valid)
        dq_out <= buf_out_data;
    end
  end

  // Sleep entry and exit each take a fixed number of cycles; state is kept while asleep is high
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      asleep    <= 1'b0;
      sleep_cnt <= 2'h0;
    end
    else if (sleep_request && !asleep)
    begin
      sleep_cnt <= (sleep_cnt == SLEEP_ENTER_LAST) ? 2'h0 : 2'(sleep_cnt + 2'h1);
      asleep    <= (sleep_cnt == SLEEP_ENTER_LAST);
    end
    else if (!sleep_request && asleep)
    begin
      sleep_cnt <= (sleep_cnt == SLEEP_EXIT_LAST) ? 2'h0 : 2'(sleep_cnt + 2'h1);
      asleep    <= (sleep_cnt != SLEEP_EXIT_LAST);
    end
    else
    begin
      sleep_cnt <= 2'h0;
    end
  end

  // Enable is gated without the clock: output enable and sleep act at once.
  // Dummy reads keep drive high but the gate keeps the pins released.
  assign dq_oe = drive & ~output_enable_n & ~sleep_request & ~asleep;

endmodule

// ### verification/sram_sequencer_properties.sv
// Port-level assertions for the SRAM sequencer
`timescale 1ns/1ns
module sram_sequencer_properties
  import sram_ctrl_pkg::*;
#(
  parameter int BYTES  = BYTES_X36,
  parameter int ADDR_W = ADDR_W_X36
)
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    chip_sel_a_n,
  input wire logic                    chip_sel_b,
  input wire logic                    chip_sel_c_n,
  input wire logic                    addr_advance_load,
  input wire logic                    write_sel_n,
  input wire logic                    clock_enable_n,
  input wire logic                    output_enable_n,
  input wire logic                    sleep_request,
  input wire logic [BYTES*BYTE_W-1:0] dq_out,
  input wire logic                    dq_oe,
  input wire logic                    asleep
);
  logic tk;
  logic go;
  logic ld;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Sleep requests are kept out of tk so the latency checks never span a frozen edge
  assign tk = !clock_enable_n && !asleep && !sleep_request;
  assign go = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  assign ld = tk && !addr_advance_load;
  chk_read_drive:
    assert property (ld && go && write_sel_n ##1 tk [*2] ##1 (!output_enable_n && !sleep_request)
      |-> dq_oe) else $error("read data not driven");
  chk_write_quiet:
    assert property (ld && go && !write_sel_n ##1 tk [*2] |=> !dq_oe) else $error("write drives");
  chk_desel_quiet:
    assert property (ld && !go ##1 (tk && addr_advance_load) [*2] |=> !dq_oe)
    else $error("deselect drives");
  chk_oe_gate:
    assert property (output_enable_n |-> !dq_oe) else $error("driven with oe high");
  chk_sleep_hiz:
    assert property (sleep_request || asleep |-> !dq_oe) else $error("driven in sleep");
  chk_ce_hold:
    assert property (clock_enable_n || asleep |=> $stable(dq_out)) else $error("output moved");
  chk_sleep_enter:
    assert property (!asleep && !sleep_request ##1 sleep_request [*2] |=> asleep)
    else $error("sleep entry late");
  chk_sleep_early:
    assert property (!asleep && !sleep_request ##1 sleep_request |=> !asleep)
    else $error("sleep entry early");
  chk_sleep_exit:
    assert property (asleep && sleep_request ##1 !sleep_request [*2] |=> !asleep)
    else $error("sleep exit late");
  chk_wake_early:
    assert property (asleep && sleep_request ##1 !sleep_request |=> asleep)
    else $error("sleep exit early");
  cover property (ld && go && write_sel_n ##3 dq_oe);
  cover property (ld && go && !write_sel_n);
  cover property ($rose(asleep));
endmodule
bind sram_sequencer sram_sequencer_properties #(.BYTES(BYTES), .ADDR_W(ADDR_W)) chk_u (.*);

// ### verification/sram_host.sv
// Host memory controller model: drives commands and late write data
`timescale 1ns/1ns
module sram_host
  import sram_ctrl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  asleep,
  output logic [17:0] addr,
  output logic        chip_sel_a_n,
  output logic        chip_sel_b,
  output logic        chip_sel_c_n,
  output logic        addr_advance_load,
  output logic        write_sel_n,
  output logic [3:0]  byte_write_n,
  output logic        clock_enable_n,
  output logic        output_enable_n,
  output logic        sleep_request,
  output logic        burst_order_sel,
  output logic [35:0] dq_in
);
  logic [35:0] wd0;
  logic [35:0] wd1;
  logic        wv0;
  logic        wv1;
  initial
  begin
    {chip_sel_a_n, chip_sel_b, chip_sel_c_n, addr_advance_load, write_sel_n} = 5'h19;
    {byte_write_n, clock_enable_n, output_enable_n, sleep_request, burst_order_sel} = 8'hf4;
    {addr, wv0, wv1, wd0, wd1, dq_in} = '0;
  end
  // c holds selects a_n,b,c_n, load, write_n, lanes, cke_n, oe_n, sleep, order
  task automatic drive(input logic [12:0] c, input logic [17:0] a, input logic wb,
                       input logic [35:0] d);
    {chip_sel_a_n, chip_sel_b, chip_sel_c_n, addr_advance_load, write_sel_n} <= c[12:8];
    {byte_write_n, clock_enable_n, output_enable_n, sleep_request, burst_order_sel} <= c[7:0];
    addr <= a;
    if (!c[3])
    begin
      wd0 <= d;
      wv0 <= wb;
    end
  endtask
  // Released data shows its inverse so a late sample cannot match by luck
  always @(posedge clk)
    if (!clock_enable_n && !asleep)
    begin
      wd1 <= wd0;
      wv1 <= wv0;
      dq_in <= wv1 ? wd1 : ~dq_in;
    end
endmodule

// ### verification/sram_sequencer_tb.sv
// Self-checking bench for the pipelined SRAM sequencer, x36 organisation
`timescale 1ns/1ns
module sram_sequencer_tb import sram_ctrl_pkg::*;;
  localparam logic [17:0] WIN = 18'h12340;
  logic        clk, rst, asleep, dq_oe, clock_enable_n, output_enable_n, sleep_request;
  logic        chip_sel_a_n, chip_sel_b, chip_sel_c_n, addr_advance_load, write_sel_n;
  logic        burst_order_sel;
  logic [3:0]  byte_write_n;
  logic [17:0] addr, base;
  logic [35:0] dq_in, dq_out;
  logic [36:0] cur, p1, p2, p3;
  logic [15:0] rs, r;
  logic [35:0] mem [int];
  logic [3:0]  bwt [6] = '{4'he, 4'hf, 4'hd, 4'hb, 4'h7, 4'h0};
  logic [2:0]  dsl [3] = '{3'b110, 3'b000, 3'b011};
  int          mode, k, err_total, checks, cyc;
  sram_sequencer dut_u (.*);
  sram_host host_u (.*);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic fail(input string m);
    err_total++;
    $display("Error %0t: %s", $time, m);
  endtask
  task automatic summarize();
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Field layout as in the host model; the reference memory is updated in command order
  task automatic step(input logic [12:0] c, input logic [17:0] a);
    logic [17:0] ea;
    logic [35:0] d;
    @(posedge clk);
    rs = lfsr(rs);
    d = {rs, ~rs, rs[3:0]};
    ea = '0;
    if (!c[3])
    begin
      if (!c[9])
      begin
        mode = (c[12:10] != 3'b010) ? 0 : (c[8] ? 1 : 2);
        base = a;
        k = 0;
      end
      else
        k++;
      ea = {base[17:2], c[0] ? base[1:0] ^ 2'(k) : base[1:0] + 2'(k)};
      for (int i = 0; i < 4; i++)
        if (mode == 2 && !c[4+i])
          mem[ea][i*9 +: 9] = d[i*9 +: 9];
    end
    cur <= {mode == 1, mem[ea]};
    host_u.drive(c, a, mode == 2, d);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      summarize();
    end
  end
  always @(posedge clk)
    if (rst)
      {p1, p2, p3} <= '0;
    else if (!clock_enable_n && !asleep)
    begin
      {p3, p2, p1} <= {p2, p1, cur};
      if (p3[36])
      begin
        checks += 2;
        if (dq_out !== p3[35:0])
          fail("read data mismatch");
        if (dq_oe !== (!output_enable_n && !sleep_request))
          fail("output enable wrong");
      end
    end
  initial
  begin
    {rst, rs, mode, k, err_total, checks, cyc, base, cur} = {1'b1, 16'h0048, 160'h0, 55'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int b = 0; b < 16; b++)
      step({3'b010, b % 4 != 0, 9'h4}, WIN + 18'(b));
    for (int c = 0; c < 8; c++)
    begin
      for (int n = 0; n < 4; n++)
        step({3'b010, n != 0, 1'b0, bwt[(n + c) % 6], 3'b010, c[2]}, WIN + 18'(c));
      for (int n = 0; n < 6; n++)
        step({3'b010, n != 0, 5'h1f, 1'b0, c == 7 && n < 2, 1'b0, c[2]}, WIN + 18'(c));
      step({dsl[c % 3], 6'h10, 4'h4}, WIN);
      step({3'b010, 10'h304}, WIN);
    end
    for (int n = 0; n < 9; n++)
      step({3'b110, 1'b0, 1'b1, 4'hf, 1'b0, 1'b1, n < 6, 1'b0}, WIN);
    for (int n = 0; n < 600; n++)
    begin
      rs = lfsr(rs);
      r = rs;
      step({r[4:2] == 1 ? 3'b110 : r[4:2] == 2 ? 3'b000 : r[4:2] == 3 ? 3'b011 : 3'b010,
            r[1:0] != 0, r[5], r[9:6], r[15:14] == 3, r[11] & r[12], n % 37 == 5, n > 299},
           WIN | 18'(r[13:10]));
    end
    repeat (4) step({3'b110, 10'h0f4}, WIN);
    summarize();
  end
endmodule
